// file: hdl/input_sync_filter.sv
// Three-stage synchroniser with a stability filter for pins from outside the clock domain
`timescale 1ns/1ps
module input_sync_filter #(
  parameter int unsigned FILTER_CYCLES = 1,
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin and filtered level
  input wire logic pin,
  output logic level
);
  localparam int CW = $clog2(FILTER_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(FILTER_CYCLES - 1);

  logic ff1, ff2, ff3;
  logic [CW-1:0] count, next_count;
  logic next_level;

  // A change counts only once stages two and three agree for the whole filter span
  always_comb begin
    next_count = '0;
    next_level = level;
    if (ff2 == ff3 && ff3 != level) begin
      if (count == LAST) begin
        next_level = ff3;
      end else begin
        next_count = count + CW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff1 <= RESET_VAL;
      ff2 <= RESET_VAL;
      ff3 <= RESET_VAL;
      count <= '0;
      level <= RESET_VAL;
    end else begin
      ff1 <= pin;
      ff2 <= ff1;
      ff3 <= ff2;
      count <= next_count;
      level <= next_level;
    end
  end
endmodule // input_sync_filter

// file: hdl/power_up_reset_sequencer.sv
// Reset time-out sequencer with reset-cause flags and special register defaults
`timescale 1ns/1ps
`include "reset_seq_cfg.svh"

// Operation
// - On power-on only, run a 72 ms power-up delay after the power-on pulse.
// - Hold the chip in reset while the power-up delay counts.
// - Time the power-up delay from its own RC-rate tick, not the oscillator.
// - Delay-disable configuration bit set skips the delay; cleared enables it.
// - After the delay, hold reset for 1024 oscillator input cycles more.
// - Settling count only in crystal modes, only after power-on or sleep wake-up.
// - Delay starts when power-on pulse ends; settling starts after the delay.
// - RC mode with delay disabled, and RC wake-up, have no time-out.
// - Time-outs run from power-on, not master clear; late release starts at once.
// - Power-on flag cleared by power-on reset only, other resets leave it.
// - Power-on reset sets both watchdog-expired and sleep-entered flags.
// - Cause codes: clear 1,1; clear in sleep 1,0; watchdog 0,1; watchdog wake 0,0.
// - Resets start at 000h; sleep wake-ups resume after the sleep instruction.
// - Interrupt wake-up with global enable runs next instruction, then vector 0004h.
// - Power-on loads status 0001 1xxx; resets load option all ones, irq 0000 000x, directions ones.
// - Wake-up keeps registers; only the cause flags and the waking interrupt flags change.
// - Unimplemented bits of reset registers read as zero.
// - Five reset kinds are told apart; watchdog wake-up resets no registers.
// - Master clear input is noise filtered so short pulses are ignored.
module power_up_reset_sequencer #(
  parameter int unsigned RC_DIV = `CLK_FREQ_KHZ / `RC_FREQ_KHZ,
  parameter int unsigned POWER_UP_DELAY_TIMER_TICKS = `POWER_UP_DELAY_TIMER_TIME_MS * `RC_FREQ_KHZ,
  parameter int unsigned OST_CYCLES = `OST_OSC_CYCLES,
  parameter int unsigned MASTER_CLEAR_PIN_FILTER_CYCLES = `MASTER_CLEAR_PIN_FILTER_NS * (`CLK_FREQ_KHZ / 1000) / 1000
) (
  // Clock and bus reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and power detector
  input wire logic power_on_pulse,
  input wire logic master_clear_pin_n,
  input wire logic oscillator_input_pin,
  // Core, watchdog and sleep logic on pclk
  input wire logic sleep_enter,
  input wire logic watchdog_timeout,
  input wire logic [7:0] irq_wake_flags,
  input wire logic [12:0] sleep_pc,
  // Reset and start outputs
  output logic chip_reset,
  output logic core_halt,
  output logic core_start,
  output reset_seq_pkg::start_info_t start_info,
  output reset_seq_pkg::special_regs_t special_regs
);
  localparam int DW = $clog2(RC_DIV);
  localparam int PW = $clog2(POWER_UP_DELAY_TIMER_TICKS + 1);
  localparam logic [DW-1:0] RC_LAST = DW'(RC_DIV - 1);
  localparam logic [PW-1:0] POWER_UP_DELAY_TIMER_LAST = PW'(POWER_UP_DELAY_TIMER_TICKS - 1);
  localparam logic [10:0] OST_LAST = 11'(OST_CYCLES - 1);

  logic por_level, clear_n_level, osc_level, osc_prev;
  logic osc_rise, rc_tick, global_irq_enable, crystal, delay_enabled, load_event;
  logic [DW-1:0] rc_count, next_rc_count;
  logic [PW-1:0] power_up_delay_timer_count, next_power_up_delay_timer_count;
  logic [10:0] ost_count, next_ost_count;
  reset_seq_pkg::seq_state_t state, next_state;
  reset_seq_pkg::reset_kind_t kind, next_kind;
  reset_seq_pkg::start_info_t next_start_info;
  reset_seq_pkg::special_regs_t next_special_regs;
  logic [7:0] status, next_status;
  logic power_on_flag, next_power_on_flag;
  logic [2:0] seq_config, next_seq_config;
  logic next_chip_reset, next_core_halt, next_core_start;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [7:0] index;
  logic setup, wr_access, mapped;

  // Power detector passes unfiltered beyond agreement
  input_sync_filter #(.FILTER_CYCLES(1), .RESET_VAL(1'b1)) por_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(power_on_pulse),
    .level(por_level)
  );

  // Short low glitches on master clear never reach the sequencer
  input_sync_filter #(.FILTER_CYCLES(MASTER_CLEAR_PIN_FILTER_CYCLES), .RESET_VAL(1'b0)) clear_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(master_clear_pin_n),
    .level(clear_n_level)
  );

  // Oscillator must run at a quarter of pclk or slower or edges are missed
  input_sync_filter #(.FILTER_CYCLES(1), .RESET_VAL(1'b0)) osc_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(oscillator_input_pin),
    .level(osc_level)
  );

  assign osc_rise = osc_level & ~osc_prev;
  assign rc_tick = (rc_count == RC_LAST);
  assign global_irq_enable = special_regs.irq_control[`GIE_BIT];
  assign crystal = (reset_seq_pkg::osc_mode_t'(seq_config[1:0])
                    != reset_seq_pkg::resistor_capacitor_mode);
  assign delay_enabled = ~seq_config[`CFG_DELAY_DIS_BIT];

  // APB decode
  assign index = paddr[9:2];
  assign setup = psel & ~penable;
  assign wr_access = psel & penable & pready & pwrite & ~pslverr;

  always_comb begin
    if (paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end else if (index == `IDX_STATUS || index == `IDX_IRQ_CTRL || index == `IDX_OPTION) begin
      mapped = 1'b1;
    end else if (index == `IDX_TRIS_A || index == `IDX_TRIS_B || index == `IDX_PWR_STATUS) begin
      mapped = 1'b1;
    end else if (index == `IDX_SEQ_CONFIG || index == `IDX_SEQ_STATE) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // Registered answer: pready rises in the first access cycle
  always_comb begin
    next_pready = setup;
    next_pslverr = setup & ~mapped;
    next_prdata = 32'h0000_0000;
    if (setup && !pwrite) begin
      if (index == `IDX_STATUS) begin
        next_prdata = {24'h00_0000, status};
      end else if (index == `IDX_IRQ_CTRL) begin
        next_prdata = {24'h00_0000, special_regs.irq_control};
      end else if (index == `IDX_OPTION) begin
        next_prdata = {24'h00_0000, special_regs.option};
      end else if (index == `IDX_TRIS_A) begin
        next_prdata = {27'h000_0000, special_regs.tris_a};
      end else if (index == `IDX_TRIS_B) begin
        next_prdata = {24'h00_0000, special_regs.tris_b};
      end else if (index == `IDX_PWR_STATUS) begin
        next_prdata = {30'h0000_0000, power_on_flag, 1'b0};
      end else if (index == `IDX_SEQ_CONFIG) begin
        next_prdata = {29'h0000_0000, seq_config};
      end else if (index == `IDX_SEQ_STATE) begin
        next_prdata = {24'h00_0000, 2'h0, kind, state};
      end
    end
  end

  // Sequencer
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_rc_count = rc_tick ? '0 : rc_count + DW'(1);
    next_power_up_delay_timer_count = power_up_delay_timer_count;
    next_ost_count = ost_count;
    next_core_start = 1'b0;
    next_start_info = start_info;
    load_event = 1'b0;
    if (por_level) begin
      next_state = reset_seq_pkg::st_hold;
      next_kind = reset_seq_pkg::kind_power_on;
      load_event = (kind != reset_seq_pkg::kind_power_on) || (state != reset_seq_pkg::st_hold);
    end else begin
      case (state)
        reset_seq_pkg::st_hold: begin
          next_power_up_delay_timer_count = '0;
          next_ost_count = '0;
          if (kind == reset_seq_pkg::kind_power_on) begin
            if (delay_enabled) begin
              next_state = reset_seq_pkg::st_delay;
            end else if (crystal) begin
              next_state = reset_seq_pkg::st_settle;
            end else begin
              next_state = reset_seq_pkg::st_wait_clear;
            end
          end else if (clear_n_level) begin
            next_state = reset_seq_pkg::st_wait_clear;
          end
        end
        reset_seq_pkg::st_delay: begin
          // Master clear does not restart the time-outs
          if (rc_tick) begin
            next_power_up_delay_timer_count = power_up_delay_timer_count + PW'(1);
            if (power_up_delay_timer_count == POWER_UP_DELAY_TIMER_LAST) begin
              next_state = crystal ? reset_seq_pkg::st_settle
                                   : reset_seq_pkg::st_wait_clear;
            end
          end
        end
        reset_seq_pkg::st_settle: begin
          if (osc_rise) begin
            next_ost_count = ost_count + 11'(1);
            if (ost_count == OST_LAST) begin
              next_state = reset_seq_pkg::st_wait_clear;
            end
          end
        end
        reset_seq_pkg::st_wait_clear: begin
          if (clear_n_level) begin
            next_state = reset_seq_pkg::st_run;
            next_core_start = 1'b1;
            next_start_info.kind = kind;
            next_start_info.vector = `PC_RESET_VAL;
            next_start_info.vector_irq_next = 1'b0;
          end
        end
        reset_seq_pkg::st_run: begin
          if (!clear_n_level) begin
            next_state = reset_seq_pkg::st_hold;
            next_kind = reset_seq_pkg::kind_clear_normal;
            load_event = 1'b1;
          end else if (watchdog_timeout) begin
            next_state = reset_seq_pkg::st_hold;
            next_kind = reset_seq_pkg::kind_watchdog_reset;
            load_event = 1'b1;
          end else if (sleep_enter) begin
            next_state = reset_seq_pkg::st_sleep;
          end
        end
        reset_seq_pkg::st_sleep, reset_seq_pkg::st_wake_settle: begin
          next_ost_count = (state == reset_seq_pkg::st_sleep) ? '0 : ost_count;
          if (!clear_n_level) begin
            next_state = reset_seq_pkg::st_hold;
            next_kind = reset_seq_pkg::kind_clear_sleep;
            load_event = 1'b1;
          end else if (state == reset_seq_pkg::st_sleep) begin
            if (watchdog_timeout || irq_wake_flags != 8'h00) begin
              next_kind = watchdog_timeout ? reset_seq_pkg::kind_watchdog_wake
                                           : reset_seq_pkg::kind_irq_wake;
              load_event = 1'b1;
              next_state = crystal ? reset_seq_pkg::st_wake_settle
                                   : reset_seq_pkg::st_run;
            end
          end else if (osc_rise) begin
            next_ost_count = ost_count + 11'(1);
            if (ost_count == OST_LAST) begin
              next_state = reset_seq_pkg::st_run;
            end
          end
          if (next_state == reset_seq_pkg::st_run) begin
            next_core_start = 1'b1;
            next_start_info.kind = next_kind;
            next_start_info.vector = sleep_pc + 13'(1);
            next_start_info.vector_irq_next =
              (next_kind == reset_seq_pkg::kind_irq_wake) & global_irq_enable;
          end
        end
        default: begin
          next_state = reset_seq_pkg::st_hold;
        end
      endcase
    end
    next_chip_reset = (next_state == reset_seq_pkg::st_hold)
                    || (next_state == reset_seq_pkg::st_delay)
                    || (next_state == reset_seq_pkg::st_settle)
                    || (next_state == reset_seq_pkg::st_wait_clear);
    next_core_halt = (next_state == reset_seq_pkg::st_sleep)
                   || (next_state == reset_seq_pkg::st_wake_settle);
  end

  // Registers: software writes first, hardware reset and wake events override them
  always_comb begin
    next_status = status;
    next_power_on_flag = power_on_flag;
    next_special_regs = special_regs;
    next_seq_config = seq_config;
    if (wr_access) begin
      if (index == `IDX_STATUS) begin
        // Cause flags are read only to software
        next_status = {pwdata[7:5], status[`STS_WDT_BIT], status[`STS_SLEEP_BIT], pwdata[2:0]};
      end else if (index == `IDX_IRQ_CTRL) begin
        next_special_regs.irq_control = pwdata[7:0];
      end else if (index == `IDX_OPTION) begin
        next_special_regs.option = pwdata[7:0];
      end else if (index == `IDX_TRIS_A) begin
        next_special_regs.tris_a = pwdata[4:0];
      end else if (index == `IDX_TRIS_B) begin
        next_special_regs.tris_b = pwdata[7:0];
      end else if (index == `IDX_PWR_STATUS) begin
        next_power_on_flag = pwdata[`PWR_POR_BIT];
      end else if (index == `IDX_SEQ_CONFIG) begin
        next_seq_config = pwdata[2:0];
      end
    end
    if (state == reset_seq_pkg::st_run && sleep_enter && next_state == reset_seq_pkg::st_sleep) begin
      next_status[`STS_WDT_BIT] = 1'b1;
      next_status[`STS_SLEEP_BIT] = 1'b0;
    end
    if (load_event) begin
      case (next_kind)
        reset_seq_pkg::kind_power_on: begin
          next_status = `STATUS_POR_VAL;
          next_power_on_flag = 1'b0;
        end
        reset_seq_pkg::kind_clear_normal: begin
          next_status = {3'h0, 1'b1, 1'b1, status[2:0]};
        end
        reset_seq_pkg::kind_clear_sleep: begin
          next_status = {3'h0, 1'b1, 1'b0, status[2:0]};
        end
        reset_seq_pkg::kind_watchdog_reset: begin
          next_status = {3'h0, 1'b0, 1'b1, status[2:0]};
        end
        reset_seq_pkg::kind_watchdog_wake: begin
          next_status = {status[7:5], 1'b0, 1'b0, status[2:0]};
        end
        default: begin
          next_status = {status[7:5], 1'b1, 1'b0, status[2:0]};
          next_special_regs.irq_control = special_regs.irq_control | irq_wake_flags;
        end
      endcase
      if (next_kind != reset_seq_pkg::kind_watchdog_wake
          && next_kind != reset_seq_pkg::kind_irq_wake) begin
        next_special_regs.option = `OPTION_RST_VAL;
        next_special_regs.irq_control = `IRQ_CTRL_RST_VAL;
        next_special_regs.tris_a = `TRIS_A_RST_VAL;
        next_special_regs.tris_b = `TRIS_B_RST_VAL;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= reset_seq_pkg::st_hold;
      kind <= reset_seq_pkg::kind_power_on;
      rc_count <= '0;
      power_up_delay_timer_count <= '0;
      ost_count <= '0;
      osc_prev <= 1'b0;
      chip_reset <= 1'b1;
      core_halt <= 1'b0;
      core_start <= 1'b0;
      start_info <= '{kind: reset_seq_pkg::kind_power_on, vector: `PC_RESET_VAL,
                      vector_irq_next: 1'b0};
      special_regs <= '{option: `OPTION_RST_VAL, irq_control: `IRQ_CTRL_RST_VAL,
                        tris_a: `TRIS_A_RST_VAL, tris_b: `TRIS_B_RST_VAL};
      status <= `STATUS_POR_VAL;
      power_on_flag <= 1'b0;
      seq_config <= `SEQ_CONFIG_RST_VAL;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      rc_count <= next_rc_count;
      power_up_delay_timer_count <= next_power_up_delay_timer_count;
      ost_count <= next_ost_count;
      osc_prev <= osc_level;
      chip_reset <= next_chip_reset;
      core_halt <= next_core_halt;
      core_start <= next_core_start;
      start_info <= next_start_info;
      special_regs <= next_special_regs;
      status <= next_status;
      power_on_flag <= next_power_on_flag;
      seq_config <= next_seq_config;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end
endmodule // power_up_reset_sequencer

// file: hdl/reset_seq_cfg.svh
// Offsets, field positions, reset values and timing figures of the reset sequencer
`ifndef RESET_SEQ_CFG_SVH
`define RESET_SEQ_CFG_SVH

// Register indices; byte address is four times the index
`define IDX_STATUS 8'h03
`define IDX_IRQ_CTRL 8'h0b
`define IDX_OPTION 8'h81
`define IDX_TRIS_A 8'h85
`define IDX_TRIS_B 8'h86
`define IDX_PWR_STATUS 8'h8e
`define IDX_SEQ_CONFIG 8'h90
`define IDX_SEQ_STATE 8'h91

// Field positions
`define STS_WDT_BIT 4
`define STS_SLEEP_BIT 3
`define PWR_POR_BIT 1
`define GIE_BIT 7
`define CFG_DELAY_DIS_BIT 2

// Reset values
`define STATUS_POR_VAL 8'h18
`define OPTION_RST_VAL 8'hff
`define IRQ_CTRL_RST_VAL 8'h00
`define TRIS_A_RST_VAL 5'h1f
`define TRIS_B_RST_VAL 8'hff
`define SEQ_CONFIG_RST_VAL 3'h1
`define PC_RESET_VAL 13'h000
`define PC_IRQ_VECTOR 13'h004

// Timing
`define CLK_FREQ_KHZ 10000
`define RC_FREQ_KHZ 1000
`define POWER_UP_DELAY_TIMER_TIME_MS 72
`define OST_OSC_CYCLES 1024
`define MASTER_CLEAR_PIN_FILTER_NS 2000

`endif

// file: hdl/reset_seq_pkg.sv
// Types shared by the reset sequencer files
package reset_seq_pkg;

  typedef enum logic [1:0] {
    low_power_crystal_mode = 2'h0,
    crystal_mode = 2'h1,
    high_speed_crystal_mode = 2'h2,
    resistor_capacitor_mode = 2'h3
  } osc_mode_t;

  // Gray codes along hold -> delay -> settle -> wait clear -> run -> sleep -> wake settle
  typedef enum logic [2:0] {
    st_hold = 3'h0,
    st_delay = 3'h1,
    st_settle = 3'h3,
    st_wait_clear = 3'h2,
    st_run = 3'h6,
    st_sleep = 3'h7,
    st_wake_settle = 3'h5
  } seq_state_t;

  typedef enum logic [2:0] {
    kind_power_on = 3'h0,
    kind_clear_normal = 3'h1,
    kind_clear_sleep = 3'h2,
    kind_watchdog_reset = 3'h3,
    kind_watchdog_wake = 3'h4,
    kind_irq_wake = 3'h5
  } reset_kind_t;

  typedef struct packed {
    reset_kind_t kind;
    logic [12:0] vector;
    logic vector_irq_next;
  } start_info_t;

  typedef struct packed {
    logic [7:0] option;
    logic [7:0] irq_control;
    logic [4:0] tris_a;
    logic [7:0] tris_b;
  } special_regs_t;

endpackage

// file: tb/pin_partner.sv
// Far-side model: power detector, master clear pin and crystal
`timescale 1ns/1ps
module pin_partner (
  // Clock and commands from the bench
  input wire logic pclk,
  input wire logic por_req,
  input wire logic clear_req,
  // Pins into the sequencer
  output logic power_on_pulse,
  output logic master_clear_pin_n,
  output logic oscillator_input_pin
);
  logic [2:0] osc_div = 3'h0;
  // Crystal runs freely; eight pclk cycles a period keeps it below pclk/6
  always_ff @(posedge pclk) begin
    osc_div <= osc_div + 3'h1;
  end
  assign oscillator_input_pin = osc_div[2];
  assign power_on_pulse = por_req;
  assign master_clear_pin_n = !clear_req;
endmodule // pin_partner

// file: tb/reset_seq_properties.sv
// Port-level checks on the reset sequencer
`timescale 1ns/1ps
module reset_seq_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins and core side
  input wire logic power_on_pulse,
  input wire logic master_clear_pin_n,
  input wire logic [12:0] sleep_pc,
  // Outputs under check
  input wire logic chip_reset,
  input wire logic core_halt,
  input wire logic core_start,
  input wire reset_seq_pkg::start_info_t start_info,
  input wire reset_seq_pkg::special_regs_t special_regs
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Glitch shorter than the filter window
  sequence s_glitch;
    !chip_reset && !power_on_pulse && $fell(master_clear_pin_n) ##1 master_clear_pin_n;
  endsequence
  property p_start_pulse;
    core_start |=> !core_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_start_released;
    core_start |-> !chip_reset && !core_halt;
  endproperty
  a_start_released: assert property (p_start_released) else $error("start in reset");
  property p_reset_start;
    core_start && start_info.kind <= reset_seq_pkg::kind_watchdog_reset |->
      start_info.vector == 13'h000 && special_regs == {8'hff, 8'h00, 5'h1f, 8'hff};
  endproperty
  a_reset_start: assert property (p_reset_start) else $error("bad reset start");
  property p_wake_vector;
    core_start && start_info.kind >= reset_seq_pkg::kind_watchdog_wake |->
      start_info.vector == sleep_pc + 13'h1;
  endproperty
  a_wake_vector: assert property (p_wake_vector) else $error("bad wake vector");
  property p_irq_vector;
    core_start && start_info.vector_irq_next |-> start_info.kind == reset_seq_pkg::kind_irq_wake;
  endproperty
  a_irq_vector: assert property (p_irq_vector) else $error("vector jump off irq");
  property p_halt_only;
    core_halt |-> !chip_reset;
  endproperty
  a_halt_only: assert property (p_halt_only) else $error("wake took reset");
  property p_por_holds;
    $rose(power_on_pulse) |-> ##6 chip_reset;
  endproperty
  a_por_holds: assert property (p_por_holds) else $error("power-on not held");
  property p_glitch;
    s_glitch |=> !chip_reset [*6];
  endproperty
  a_glitch: assert property (p_glitch) else $error("glitch caused reset");
  property p_clear_release;
    $fell(chip_reset) |-> $past(master_clear_pin_n, 5);
  endproperty
  a_clear_release: assert property (p_clear_release) else $error("release in clear");
endmodule // reset_seq_properties

bind power_up_reset_sequencer reset_seq_properties reset_seq_properties_inst (.pclk, .presetn,
  .power_on_pulse, .master_clear_pin_n, .sleep_pc, .chip_reset, .core_halt, .core_start,
  .start_info, .special_regs);

// file: tb/tb_top.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
`include "reset_seq_cfg.svh"
module tb_top;
  logic pclk;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic por_req = 1'b0;
  logic clear_req = 1'b0;
  logic power_on_pulse;
  logic master_clear_pin_n;
  logic oscillator_input_pin;
  logic sleep_enter = 1'b0;
  logic watchdog_timeout = 1'b0;
  logic [7:0] irq_wake_flags = 8'h00;
  logic [12:0] sleep_pc = 13'h123;
  logic chip_reset;
  logic core_halt;
  logic core_start;
  reset_seq_pkg::start_info_t start_info;
  reset_seq_pkg::special_regs_t special_regs;
  int n_errors = 0;
  int check_count = 0;

  power_up_reset_sequencer #(.POWER_UP_DELAY_TIMER_TICKS(8), .OST_CYCLES(16), .MASTER_CLEAR_PIN_FILTER_CYCLES(3))
    power_up_reset_sequencer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .power_on_pulse, .master_clear_pin_n,
    .oscillator_input_pin, .sleep_enter, .watchdog_timeout, .irq_wake_flags, .sleep_pc,
    .chip_reset, .core_halt, .core_start, .start_info, .special_regs);
  pin_partner pin_partner_inst (.pclk, .por_req, .clear_req, .power_on_pulse,
    .master_clear_pin_n, .oscillator_input_pin);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the released bus reach an edge before any next setup
    @(posedge pclk);
  endtask

  task automatic reg_wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, idx, wd, d, e);
    chk({31'h0, e}, 32'h0);
  endtask

  task automatic reg_rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, 32'h0, d, e);
    chk(d, exp);
  endtask

  // Start info is {kind, vector, jump to irq vector}
  task automatic wait_start(input int limit, input logic [16:0] exp, output int n);
    n = 0;
    while (core_start !== 1'b1 && n < limit) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, core_start}, 32'h1);
    chk({15'h0, start_info}, {15'h0, exp});
  endtask

  task automatic t_power_on();
    int n;
    logic [31:0] d;
    logic e;
    wait_start(1000, {3'h0, 13'h000, 1'b0}, n);
    chk({31'h0, n >= 200}, 32'h1);
    reg_rd(`IDX_STATUS, 32'h18);
    reg_rd(`IDX_PWR_STATUS, 32'h0);
    reg_rd(`IDX_OPTION, 32'hff);
    reg_rd(`IDX_TRIS_A, 32'h1f);
    reg_rd(`IDX_IRQ_CTRL, 32'h0);
    reg_rd(`IDX_TRIS_B, 32'hff);
    reg_rd(`IDX_SEQ_STATE, {26'h0, reset_seq_pkg::kind_power_on, reset_seq_pkg::st_run});
    reg_wr(`IDX_PWR_STATUS, 32'hff);
    reg_rd(`IDX_PWR_STATUS, 32'h2);
    apb(1'b0, 8'h7f, 32'h0, d, e);
    chk({31'h0, e}, 32'h1);
  endtask

  task automatic t_master_clear_pin();
    int n;
    reg_wr(`IDX_OPTION, 32'h0);
    clear_req <= 1'b1;
    @(posedge pclk);
    clear_req <= 1'b0;
    repeat (15) @(posedge pclk);
    chk({31'h0, chip_reset}, 32'h0);
    clear_req <= 1'b1;
    repeat (30) @(posedge pclk);
    chk({31'h0, chip_reset}, 32'h1);
    clear_req <= 1'b0;
    wait_start(100, {3'h1, 13'h000, 1'b0}, n);
    reg_rd(`IDX_STATUS, 32'h18);
    reg_rd(`IDX_OPTION, 32'hff);
    reg_rd(`IDX_PWR_STATUS, 32'h2);
  endtask

  task automatic t_wdt_reset();
    int n;
    watchdog_timeout <= 1'b1;
    @(posedge pclk);
    watchdog_timeout <= 1'b0;
    wait_start(100, {3'h3, 13'h000, 1'b0}, n);
    reg_rd(`IDX_STATUS, 32'h08);
  endtask

  // No flags means the watchdog wakes the core
  task automatic t_sleep(input logic [7:0] flags, input logic [16:0] exp,
      input logic [31:0] st, input logic [31:0] irq);
    int n;
    reg_wr(`IDX_OPTION, 32'h5a);
    reg_wr(`IDX_IRQ_CTRL, 32'h80);
    sleep_enter <= 1'b1;
    @(posedge pclk);
    sleep_enter <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, core_halt}, 32'h1);
    reg_rd(`IDX_STATUS, 32'h10);
    if (flags == 8'h00) watchdog_timeout <= 1'b1;
    else irq_wake_flags <= flags;
    @(posedge pclk);
    watchdog_timeout <= 1'b0;
    wait_start(500, exp, n);
    irq_wake_flags <= 8'h00;
    chk({31'h0, n >= 120}, 32'h1);
    reg_rd(`IDX_STATUS, st);
    reg_rd(`IDX_OPTION, 32'h5a);
    reg_rd(`IDX_IRQ_CTRL, irq);
  endtask

  // Clear held through the whole time-out must start at once on release
  task automatic t_por(input logic [31:0] cfg, input int hold);
    int n;
    reg_wr(`IDX_SEQ_CONFIG, cfg);
    clear_req <= (hold > 0);
    por_req <= 1'b1;
    repeat (20) @(posedge pclk);
    por_req <= 1'b0;
    if (hold > 0) begin
      repeat (hold) @(posedge pclk);
      clear_req <= 1'b0;
    end
    wait_start(20, {3'h0, 13'h000, 1'b0}, n);
    reg_rd(`IDX_PWR_STATUS, 32'h0);
    reg_wr(`IDX_PWR_STATUS, 32'h2);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    $display("MISMATCH at %0t: run timed out", $time);
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_power_on();
    t_master_clear_pin();
    t_wdt_reset();
    t_sleep(8'h00, {3'h4, 13'h124, 1'b0}, 32'h00, 32'h80);
    t_sleep(8'h01, {3'h5, 13'h124, 1'b1}, 32'h10, 32'h81);
    t_por(32'h7, 0);
    t_por(32'h1, 300);
    t_por(32'h6, 300);
    wrap_up();
  end
endmodule // tb_top
